/* include/cvm_consts.svh */
// offsets, field positions, reset values and timing counts of the window monitor
`ifndef CVM_CONSTS_SVH
`define CVM_CONSTS_SVH

// ------------------------------------------------------------
// register pointer codes
// ------------------------------------------------------------
`define CVM_PTR_RESULT 3'h0
`define CVM_PTR_STATUS 3'h1
`define CVM_PTR_CONFIG 3'h2
`define CVM_PTR_UNDER 3'h3
`define CVM_PTR_OVER 3'h4
`define CVM_PTR_MARGIN 3'h5
`define CVM_PTR_LOWEST 3'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CVM_CFG_INTERVAL_HI 7
`define CVM_CFG_INTERVAL_LO 5
`define CVM_CFG_HOLD 4
`define CVM_CFG_FLAG_EN 3
`define CVM_CFG_PIN_EN 2
`define CVM_CFG_RSVD 1
`define CVM_CFG_POLARITY 0
`define CVM_STAT_OVER 1
`define CVM_STAT_UNDER 0
`define CVM_RES_SUMMARY 15

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CVM_RST_CONFIG 8'h00
`define CVM_RST_UNDER 12'h000
`define CVM_RST_OVER 12'hFFF
`define CVM_RST_MARGIN 12'h000
`define CVM_RST_LOWEST 12'hFFF
`define CVM_RST_RESULT 12'h000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CVM_CLK_PERIOD_NS 25
`define CVM_CONV_PERIOD_NS 1000
`define CVM_CONV_PERIOD_CYC ((`CVM_CONV_PERIOD_NS + `CVM_CLK_PERIOD_NS - 1) / `CVM_CLK_PERIOD_NS)
`define CVM_INTERVAL_SHIFT_BASE 4

`endif

/* include/cvm_pkg.sv */
// types shared by the window monitor modules
package cvm_pkg;

  typedef struct packed {
    logic [2:0] interval;
    logic hold;
    logic flag_en;
    logic pin_en;
    logic rsvd;
    logic polarity;
  } cvm_cfg_s;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } cvm_conv_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] ptr;
    logic [15:0] wdata;
  } cvm_reg_req_s;

  typedef struct packed {
    logic [23:0] count;
    logic [2:0] code;
  } cvm_timer_s;

  typedef struct packed {
    cvm_cfg_s cfg;
    logic [11:0] under_limit;
    logic [11:0] over_limit;
    logic [11:0] clear_margin;
    logic [11:0] lowest_seen;
    logic [11:0] result;
    logic [15:0] rdata;
    logic conv_req;
    logic pin_out;
    logic pin_oe;
  } cvm_main_s;

endpackage : cvm_pkg

/* core/cvm_interval_timer.sv */
// automatic conversion interval timer
`timescale 1ns/1ps
`include "cvm_consts.svh"

module cvm_interval_timer #(
  parameter int unsigned PERIOD_CYC = `CVM_CONV_PERIOD_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] interval,
  output logic tick
);

  cvm_pkg::cvm_timer_s st;
  cvm_pkg::cvm_timer_s next_st;
  logic [23:0] span;

  // ------------------------------------------------------------
  // span: period times 32 .. 2048
  // ------------------------------------------------------------
  always_comb begin
    // shift amount held at 5 bits so that codes 4..7 do not wrap
    span = 24'(PERIOD_CYC) << (5'(interval) + 5'(`CVM_INTERVAL_SHIFT_BASE));
  end

  always_comb begin
    next_st = st;
    tick = 1'b0;
    next_st.code = interval;
    if (interval == 3'h0) begin
      next_st.count = 24'h000000;
    end else if (interval != st.code) begin
      next_st.count = 24'h000000;
      tick = 1'b1;
    end else if (st.count >= span - 24'h000001) begin
      next_st.count = 24'h000000;
      tick = 1'b1;
    end else begin
      next_st.count = st.count + 24'h000001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : cvm_interval_timer

/* core/cvm_limit_flag.sv */
// one out-of-range flag with hysteresis and hold
`timescale 1ns/1ps

module cvm_limit_flag #(
  parameter bit IS_OVER = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input cvm_pkg::cvm_conv_s conv,
  input wire logic [11:0] limit,
  input wire logic [11:0] margin,
  input wire logic hold,
  input wire logic clr,
  output logic flag
);

  logic next_flag;
  logic violate;
  logic back_inside;

  always_comb begin
    if (IS_OVER) begin
      violate = conv.data > limit;
      back_inside = ({1'b0, conv.data} + {1'b0, margin}) < {1'b0, limit};
    end else begin
      violate = conv.data < limit;
      back_inside = {1'b0, conv.data} > ({1'b0, limit} + {1'b0, margin});
    end
  end

  always_comb begin
    next_flag = flag;
    if (conv.valid && violate) begin
      // set on violation, wins over clear
      next_flag = 1'b1;
    end else if (clr) begin
      next_flag = 1'b0;
    end else if (conv.valid && !hold && back_inside) begin
      // self-clear past margin; hold blocks it
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : cvm_limit_flag

/* core/cvm_window_monitor.sv */
// conversion window monitor: config, limits, flags, alert pin, lowest tracker
// Operation
// - interval code zero keeps automatic conversion off, the reset state.
// - non-zero interval code starts repeated automatic conversions.
// - codes 1..7 space conversions at period times 32..2048.
// - hold clear lets flags self-clear once back inside past margin.
// - hold set keeps flags until host writes one to them.
// - summary enable gates result bit 15; otherwise it reads zero.
// - pin enable zero releases alert pin; one drives it.
// - polarity bit zero makes pin active low, one active high.
// - variants without the pin ignore pin enable and polarity.
// - bits 15:12 of limit, margin, tracker read zero; host writes zero.
// - under limit holds 12 bits, resets 000; result below raises under.
// - over limit holds 12 bits, resets FFF; result above raises over.
// - clearing needs the result back inside by more than the margin.
// - in auto mode a smaller result replaces lowest seen.
// - lowest seen resets to FFF; host may rewrite FFF anytime.
// - lowest seen updates only in automatic mode.
// - pointer 2..6 selects config, under, over, margin, lowest.
// - over flag, status bit 1, sets when result exceeds over limit.
// - under flag, status bit 0, sets when result below under limit.
// - with summary enabled, bit 15 high while either flag set.
// - host writing one to a flag bit clears it.
`timescale 1ns/1ps
`include "cvm_consts.svh"

module cvm_window_monitor #(
  parameter int unsigned CONV_PERIOD_CYC = `CVM_CONV_PERIOD_CYC,
  parameter bit HAS_ALERT_PIN = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input cvm_pkg::cvm_reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic conv_req,
  input cvm_pkg::cvm_conv_s conv,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  output logic auto_active
);

  cvm_pkg::cvm_main_s st;
  cvm_pkg::cvm_main_s next_st;
  logic auto_tick;
  logic flag_over;
  logic flag_under;
  logic clr_over;
  logic clr_under;
  logic any_flag;
  logic auto_en;

  // ------------------------------------------------------------
  // register select decode
  // ------------------------------------------------------------
  function automatic logic wr_hit(input cvm_pkg::cvm_reg_req_s req, input logic [2:0] ptr);
    wr_hit = req.wr && (req.ptr == ptr);
  endfunction : wr_hit

  function automatic logic [15:0] pad12(input logic [11:0] v);
    pad12 = {4'h0, v};
  endfunction : pad12

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  cvm_interval_timer #(
    .PERIOD_CYC(CONV_PERIOD_CYC)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .interval(st.cfg.interval),
    .tick(auto_tick)
  );

  cvm_limit_flag #(
    .IS_OVER(1'b1)
  ) u_over (
    .mclk(mclk),
    .rst_n(rst_n),
    .conv(conv),
    .limit(st.over_limit),
    .margin(st.clear_margin),
    .hold(st.cfg.hold),
    .clr(clr_over),
    .flag(flag_over)
  );

  cvm_limit_flag #(
    .IS_OVER(1'b0)
  ) u_under (
    .mclk(mclk),
    .rst_n(rst_n),
    .conv(conv),
    .limit(st.under_limit),
    .margin(st.clear_margin),
    .hold(st.cfg.hold),
    .clr(clr_under),
    .flag(flag_under)
  );

  // ------------------------------------------------------------
  // flag clears and summary
  // ------------------------------------------------------------
  always_comb begin
    clr_over = wr_hit(reg_req, `CVM_PTR_STATUS) && reg_req.wdata[`CVM_STAT_OVER];
    clr_under = wr_hit(reg_req, `CVM_PTR_STATUS) && reg_req.wdata[`CVM_STAT_UNDER];
    any_flag = flag_over | flag_under;
    // automatic mode off at zero code
    auto_en = st.cfg.interval != 3'h0;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.conv_req = 1'b0;

    if (auto_tick) begin
      next_st.conv_req = 1'b1;
    end
    // normal mode: reading the result starts a conversion
    if (!auto_en && reg_req.rd && reg_req.ptr == `CVM_PTR_RESULT) begin
      next_st.conv_req = 1'b1;
    end

    if (conv.valid) begin
      next_st.result = conv.data;
    end

    // tracker only in automatic mode, strict less
    if (conv.valid && auto_en && conv.data < st.lowest_seen) begin
      next_st.lowest_seen = conv.data;
    end

    if (wr_hit(reg_req, `CVM_PTR_CONFIG)) begin
      next_st.cfg = cvm_pkg::cvm_cfg_s'(reg_req.wdata[7:0]);
      next_st.cfg.rsvd = 1'b0;
    end
    if (wr_hit(reg_req, `CVM_PTR_UNDER)) begin
      next_st.under_limit = reg_req.wdata[11:0];
    end
    if (wr_hit(reg_req, `CVM_PTR_OVER)) begin
      next_st.over_limit = reg_req.wdata[11:0];
    end
    if (wr_hit(reg_req, `CVM_PTR_MARGIN)) begin
      next_st.clear_margin = reg_req.wdata[11:0];
    end
    if (wr_hit(reg_req, `CVM_PTR_LOWEST)) begin
      next_st.lowest_seen = reg_req.wdata[11:0];
    end

    if (reg_req.rd) begin
      unique case (reg_req.ptr)
        `CVM_PTR_RESULT: begin
          next_st.rdata = pad12(st.result);
          next_st.rdata[`CVM_RES_SUMMARY] = st.cfg.flag_en & any_flag;
        end
        `CVM_PTR_STATUS: begin
          next_st.rdata = {14'h0, flag_over, flag_under};
        end
        `CVM_PTR_CONFIG: begin
          next_st.rdata = {8'h00, st.cfg};
        end
        `CVM_PTR_UNDER: begin
          next_st.rdata = pad12(st.under_limit);
        end
        `CVM_PTR_OVER: begin
          next_st.rdata = pad12(st.over_limit);
        end
        `CVM_PTR_MARGIN: begin
          next_st.rdata = pad12(st.clear_margin);
        end
        `CVM_PTR_LOWEST: begin
          next_st.rdata = pad12(st.lowest_seen);
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end

    next_st.pin_oe = HAS_ALERT_PIN && st.cfg.pin_en;
    if (HAS_ALERT_PIN && st.cfg.polarity) begin
      next_st.pin_out = any_flag;
    end else begin
      next_st.pin_out = ~any_flag;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st.cfg <= cvm_pkg::cvm_cfg_s'(`CVM_RST_CONFIG);
      st.under_limit <= `CVM_RST_UNDER;
      st.over_limit <= `CVM_RST_OVER;
      st.clear_margin <= `CVM_RST_MARGIN;
      st.lowest_seen <= `CVM_RST_LOWEST;
      st.result <= `CVM_RST_RESULT;
      st.rdata <= 16'h0000;
      st.conv_req <= 1'b0;
      st.pin_out <= 1'b1;
      st.pin_oe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    reg_rdata = st.rdata;
    conv_req = st.conv_req;
    alert_pin_out = st.pin_out;
    alert_pin_oe = st.pin_oe;
    auto_active = auto_en;
  end

endmodule : cvm_window_monitor

/* tb/cvm_sva.sv */
// port assertions of the window monitor
`timescale 1ns/1ps
module cvm_sva #(
  parameter int unsigned CONV_PERIOD_CYC = 1,
  parameter bit HAS_ALERT_PIN = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input cvm_pkg::cvm_reg_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic conv_req,
  input cvm_pkg::cvm_conv_s conv,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe,
  input wire logic auto_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_cfg_wr;
    reg_req.wr && reg_req.ptr == 3'h2;
  endsequence
  sequence s_lim_wr_rd;
    reg_req.wr && reg_req.ptr inside {3'h3, 3'h4, 3'h5} ##1
      reg_req.rd && !reg_req.wr && reg_req.ptr == $past(reg_req.ptr);
  endsequence
  reset_state_a: assert property (disable iff (1'b0)
    !rst_n |=> !alert_pin_oe && !conv_req && !auto_active && reg_rdata == 16'h0000)
    else $error("reset state wrong");
  auto_follow_a: assert property (
    s_cfg_wr |=> auto_active == (|$past(reg_req.wdata[7:5])))
    else $error("auto mode not following config");
  auto_start_a: assert property (
    $rose(auto_active) |-> ##[0:2] conv_req)
    else $error("no request after auto start");
  normal_conv_a: assert property (
    reg_req.rd && reg_req.ptr == 3'h0 && !auto_active |=> conv_req)
    else $error("result read gave no request");
  pin_enable_a: assert property (
    s_cfg_wr ##1 !reg_req.wr |=> alert_pin_oe == (HAS_ALERT_PIN && $past(reg_req.wdata[2], 2)))
    else $error("pin enable wrong");
  cfg_read_a: assert property (
    reg_req.rd && reg_req.ptr == 3'h2 |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[1])
    else $error("config reserved bits set");
  unmapped_rd_a: assert property (
    reg_req.rd && reg_req.ptr == 3'h7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved");
  limit_rw_a: assert property (
    s_lim_wr_rd |=> reg_rdata == {4'h0, $past(reg_req.wdata[11:0], 2)})
    else $error("limit readback wrong");
endmodule : cvm_sva
bind cvm_window_monitor cvm_sva #(
  .CONV_PERIOD_CYC(CONV_PERIOD_CYC),
  .HAS_ALERT_PIN(HAS_ALERT_PIN)
) u_sva (.mclk, .rst_n, .reg_req, .reg_rdata, .conv_req, .conv, .alert_pin_out,
  .alert_pin_oe, .auto_active);

/* tb/cvm_conv_model.sv */
// converter model answering conversion requests
`timescale 1ns/1ps
module cvm_conv_model #(
  parameter int LAT = 3
) (
  input wire logic mclk,
  input wire logic conv_req,
  input wire logic [11:0] level,
  output cvm_pkg::cvm_conv_s conv
);
  int cnt = 0;
  initial conv = '0;
  always @(posedge mclk) begin
    conv.valid <= 1'b0;
    // data meaningless outside the result cycle
    conv.data <= ~conv.data;
    if (conv_req) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (cnt == 1) begin
      conv.valid <= 1'b1;
      conv.data <= level;
    end
  end
endmodule : cvm_conv_model

/* tb/testbench.sv */
// self-checking bench of the window monitor
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  cvm_pkg::cvm_reg_req_s reg_req = '0;
  cvm_pkg::cvm_conv_s conv;
  logic [15:0] reg_rdata;
  logic conv_req;
  logic alert_pin_out;
  logic alert_pin_oe;
  logic auto_active;
  logic [11:0] level = 12'h000;
  logic [15:0] rv;
  int err_count = 0;
  int checks = 0;
  always #12.5 mclk = ~mclk;
  cvm_window_monitor #(.CONV_PERIOD_CYC(1)) u_dut (.mclk, .rst_n, .reg_req, .reg_rdata,
    .conv_req, .conv, .alert_pin_out, .alert_pin_oe, .auto_active);
  cvm_conv_model #(.LAT(3)) u_conv (.mclk, .conv_req, .level, .conv);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // optional write cycle, then optional read cycle
  task automatic acc(input logic w, input logic r, input logic [2:0] p, input logic [15:0] d);
    @(posedge mclk);
    if (w) begin
      reg_req <= '{1'b1, 1'b0, p, d};
      @(posedge mclk);
    end
    reg_req <= '{1'b0, r, p, d};
    if (r) begin
      @(posedge mclk);
      reg_req.rd <= 1'b0;
      #1 rv = reg_rdata;
    end
  endtask : acc
  task automatic cvt(input logic [11:0] v);
    level = v;
    acc(1'b0, 1'b1, 3'h0, 16'h0000);
    repeat (8) @(posedge mclk);
  endtask : cvt
  task automatic stat();
    acc(1'b0, 1'b1, 3'h1, 16'h0000);
  endtask : stat
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (conv_req !== 1'b1 && n < 2200);
    if (n >= 2200) begin
      err_count++;
      finish_test();
    end
  endtask : gap
  task automatic t_reset();
    logic [15:0] exp [1:7];
    exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0FFF, 16'h0000, 16'h0FFF, 16'h0000};
    for (int p = 1; p < 8; p++) begin
      acc(1'b0, 1'b1, p[2:0], 16'h0000);
      chk(rv, exp[p]);
    end
    chk({15'h0, auto_active}, 16'h0000);
  endtask : t_reset
  task automatic t_alerts();
    acc(1'b1, 1'b1, 3'h3, 16'h0100);
    chk(rv, 16'h0100);
    acc(1'b1, 1'b1, 3'h4, 16'h0800);
    chk(rv, 16'h0800);
    acc(1'b1, 1'b1, 3'h5, 16'h0010);
    chk(rv, 16'h0010);
    acc(1'b1, 1'b0, 3'h2, 16'h000D);
    cvt(12'h900);
    stat();
    chk(rv, 16'h0002);
    chk({14'h0, alert_pin_oe, alert_pin_out}, 16'h0003);
    acc(1'b0, 1'b1, 3'h0, 16'h0000);
    chk(rv, 16'h8900);
    cvt(12'h7F0);
    stat();
    chk(rv, 16'h0002);
    cvt(12'h7EF);
    stat();
    chk(rv, 16'h0000);
    chk({14'h0, alert_pin_oe, alert_pin_out}, 16'h0002);
    acc(1'b1, 1'b0, 3'h2, 16'h000C);
    cvt(12'h100);
    stat();
    chk(rv, 16'h0000);
    cvt(12'h0FF);
    stat();
    chk(rv, 16'h0001);
    chk({14'h0, alert_pin_oe, alert_pin_out}, 16'h0002);
    acc(1'b1, 1'b0, 3'h2, 16'h001C);
    cvt(12'h500);
    stat();
    chk(rv, 16'h0001);
    acc(1'b1, 1'b1, 3'h1, 16'h0001);
    chk(rv, 16'h0000);
    acc(1'b1, 1'b0, 3'h2, 16'h0014);
    cvt(12'hA00);
    acc(1'b0, 1'b1, 3'h0, 16'h0000);
    chk(rv, 16'h0A00);
    acc(1'b1, 1'b0, 3'h2, 16'h0010);
    repeat (2) @(posedge mclk);
    #1;
    chk({15'h0, alert_pin_oe}, 16'h0000);
  endtask : t_alerts
  task automatic t_auto();
    int n;
    cvt(12'h050);
    acc(1'b0, 1'b1, 3'h6, 16'h0000);
    chk(rv, 16'h0FFF);
    level = 12'h300;
    for (int c = 1; c < 8; c++) begin
      acc(1'b1, 1'b0, 3'h2, {8'h00, c[2:0], 5'h00});
      gap(n);
      gap(n);
      gap(n);
      chk(n[15:0], 16'(32 << (c - 1)));
    end
    acc(1'b0, 1'b1, 3'h6, 16'h0000);
    chk(rv, 16'h0300);
    level = 12'h400;
    gap(n);
    gap(n);
    acc(1'b0, 1'b1, 3'h6, 16'h0000);
    chk(rv, 16'h0300);
    acc(1'b1, 1'b0, 3'h6, 16'h0FFF);
    gap(n);
    gap(n);
    acc(1'b0, 1'b1, 3'h6, 16'h0000);
    chk(rv, 16'h0400);
    acc(1'b1, 1'b0, 3'h2, 16'h0000);
    #1;
    chk({15'h0, auto_active}, 16'h0000);
  endtask : t_auto
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_alerts();
    t_auto();
    finish_test();
  end
endmodule : testbench
